// >>> rtl/cable_vdo_pkg.sv
// Purpose: Shared constants and carriers for the cable identity object encoder
// Assumes: 32-bit register port, one word per register, byte addresses
// Notes:   Every field position, code and reset value of the object lives here
package cable_vdo_pkg;

   // Register byte offsets
   localparam logic [7:0]  CFG_OFS       = 8'h00;  // Field configuration
   localparam logic [7:0]  CTRL_OFS      = 8'h04;  // Product type and build strobe
   localparam logic [7:0]  STAT_OFS      = 8'h08;  // Status flags
   localparam logic [7:0]  VDO_OFS       = 8'h0c;  // Assembled object, read only

   // Object field positions (low bit of each field)
   localparam int          HW_LSB        = 28;
   localparam int          FW_LSB        = 24;
   localparam int          VER_LSB       = 21;
   localparam int          PLUG_LSB      = 18;
   localparam int          LAT_LSB       = 13;
   localparam int          TERM_LSB      = 11;
   localparam int          VMAX_LSB      = 9;
   localparam int          CUR_LSB       = 5;
   localparam int          SS_LSB        = 0;

   // Legal codes
   localparam logic [2:0]  VER_1_0       = 3'h0;
   localparam logic [1:0]  PLUG_TYPEC    = 2'h2;
   localparam logic [1:0]  PLUG_CAPTIVE  = 2'h3;
   localparam logic [3:0]  LAT_MIN       = 4'h1;
   localparam logic [3:0]  LAT_MAX       = 4'h8;
   localparam logic [1:0]  TERM_NO_VCONN = 2'h0;
   localparam logic [1:0]  TERM_VCONN    = 2'h1;
   localparam logic [1:0]  CUR_3A        = 2'h1;
   localparam logic [1:0]  CUR_5A        = 2'h2;
   localparam logic [2:0]  SS_MAX        = 3'h2;

   // Product type codes held in the control register
   localparam logic [2:0]  PT_PASSIVE    = 3'h3;
   localparam logic [2:0]  PT_ACTIVE     = 3'h4;

   // Reset values: Type-C plug, 1 m, no VCONN, 20 V, 3 A, USB 2.0 only
   localparam logic [31:0] CFG_RESET     = 32'h0008_2020;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0003;

   // Configuration fields as software writes them
   typedef struct packed {
      logic [3:0] hw_ver;
      logic [3:0] fw_ver;
      logic [2:0] obj_ver;
      logic       rsv20;
      logic [1:0] plug;
      logic       rsv17;
      logic [3:0] latency;
      logic [1:0] term;
      logic [1:0] vmax;
      logic [1:0] rsv8_7;
      logic [1:0] current;
      logic [1:0] rsv4_3;
      logic [2:0] ss;
   } vdo_fields_s;

   // Register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;

   // Object handed to the message transmitter
   typedef struct packed {
      logic        valid;
      logic [31:0] word;
   } vdo_out_s;

endpackage : cable_vdo_pkg

// >>> rtl/vdo_field_check.sv
// Purpose: Flags a field code outside its legal range
// Assumes: Legal codes form one contiguous range lo..hi
// Notes:   Instantiated once per constrained field
`timescale 1ns/1ps
module vdo_field_check #(
   parameter int W = 2
) (
   // Field and its range
   input  wire logic [W-1:0] code,
   input  wire logic [W-1:0] lo,
   input  wire logic [W-1:0] hi,
   // Result
   output      logic         bad
);
   // Purely combinational range test
   assign bad = (code < lo) || (code > hi);
endmodule : vdo_field_check

// >>> rtl/cable_vdo_encoder.sv
// Purpose: Builds the 32-bit cable identity data object from stored fields
// Assumes: Register port synchronous to ref_clk; transmitter takes vdo on valid
// Notes:   Illegal codes are replaced by safe legal ones before packing
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module cable_vdo_encoder
   import cable_vdo_pkg::*;
(
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   resetn,
   // Register port
   input  wire cable_vdo_pkg::reg_req_s req,
   output      logic [31:0]            rdata,
   // Transmitter side
   input  wire logic                   build_req,
   output      cable_vdo_pkg::vdo_out_s vdo
);
   import cable_vdo_pkg::*;

   // All state of the block
   typedef struct packed {
      logic [31:0] cfg;       // Stored field values
      logic [2:0]  ptype;     // Advertised product type
      logic        id_only;   // Plug supports identity discovery only
      logic        build;     // Software build request pending
      logic        sent;      // Sticky: an object was issued
      logic        refused;   // Sticky: product type refused a build
      logic        fixed;     // Sticky: a stored code was corrected
      logic [31:0] word;      // Last assembled object
      logic [31:0] rdata;     // Read data, one cycle after strobe
      logic        valid;     // Object strobe to the transmitter
   } state_s;

   state_s       state_reg;   // Registered state
   state_s       state_next;  // Next state
   vdo_fields_s  f;           // Stored fields viewed by name
   logic         plug_bad;    // Plug code reserved
   logic         lat_bad;     // Latency code reserved
   logic         ss_bad;      // Signalling code reserved
   logic         cur_bad;     // Current code reserved
   logic         term_bad;    // Termination code reserved
   logic         any_bad;     // Any correction needed
   logic         type_ok;     // Product type may carry this object
   logic         do_build;    // Build this cycle
   logic [31:0]  assembled;   // Word being packed

   assign f = vdo_fields_s'(state_reg.cfg);

   // Range checks on constrained fields
   vdo_field_check #(.W(2)) u_plug (.code(f.plug), .lo(PLUG_TYPEC),
      .hi(PLUG_CAPTIVE), .bad(plug_bad));
   vdo_field_check #(.W(4)) u_lat (.code(f.latency), .lo(LAT_MIN),
      .hi(LAT_MAX), .bad(lat_bad));
   vdo_field_check #(.W(3)) u_ss (.code(f.ss), .lo(VER_1_0),
      .hi(SS_MAX), .bad(ss_bad));
   vdo_field_check #(.W(2)) u_cur (.code(f.current), .lo(CUR_3A),
      .hi(CUR_5A), .bad(cur_bad));
   vdo_field_check #(.W(2)) u_term (.code(f.term), .lo(TERM_NO_VCONN),
      .hi(TERM_VCONN), .bad(term_bad));

   assign any_bad  = plug_bad | lat_bad | ss_bad | cur_bad | term_bad;
   // Only passive and active product types carry this object
   assign type_ok  = (state_reg.ptype == PT_PASSIVE) || (state_reg.ptype == PT_ACTIVE);
   assign do_build = (build_req | state_reg.build) & type_ok;

   // Pack the object; reserved codes fall back to one fixed safe code per field
   always_comb begin
      assembled = '0;
      assembled[HW_LSB +: 4]   = f.hw_ver;
      assembled[FW_LSB +: 4]   = f.fw_ver;
      assembled[VER_LSB +: 3]  = VER_1_0;
      assembled[PLUG_LSB +: 2] = plug_bad ? PLUG_TYPEC : f.plug;
      // Unknown latency is reported as the worst class, never too short
      assembled[LAT_LSB +: 4]  = lat_bad ? LAT_MAX : f.latency;
      if (state_reg.id_only || term_bad) begin
         assembled[TERM_LSB +: 2] = TERM_NO_VCONN;
      end else begin
         assembled[TERM_LSB +: 2] = f.term;
      end
      assembled[VMAX_LSB +: 2] = f.vmax;
      // Unknown current is reported as the lower rating for safety
      assembled[CUR_LSB +: 2]  = cur_bad ? CUR_3A : f.current;
      assembled[SS_LSB +: 3]   = ss_bad ? VER_1_0 : f.ss;
   end

   // Next-state logic: register port, build and status
   always_comb begin
      state_next       = state_reg;
      state_next.valid = 1'b0;
      state_next.rdata = '0;
      // Build request from the transmitter or software
      if (do_build) begin
         state_next.word  = assembled;
         state_next.valid = 1'b1;
         state_next.sent  = 1'b1;
         state_next.build = 1'b0;
      end else if (build_req | state_reg.build) begin
         state_next.refused = 1'b1;
         state_next.build   = 1'b0;
      end
      if (do_build && any_bad) begin
         state_next.fixed = 1'b1;
      end
      // Register writes; a status write clears flags, new events win
      if (req.wr) begin
         unique case (req.addr)
            CFG_OFS: begin
               state_next.cfg = req.wdata;
            end
            CTRL_OFS: begin
               state_next.ptype   = req.wdata[2:0];
               state_next.id_only = req.wdata[4];
               if (req.wdata[8]) begin
                  state_next.build = 1'b1;
               end
            end
            STAT_OFS: begin
               // Set wins over clear in the same cycle
               state_next.sent    = (state_reg.sent & ~req.wdata[0]) | do_build;
               state_next.refused = (state_reg.refused & ~req.wdata[1]) |
                                    (~type_ok & (build_req | state_reg.build));
               state_next.fixed   = (state_reg.fixed & ~req.wdata[2]) | (do_build & any_bad);
            end
            default: begin
               // Unmapped or read-only address: write ignored
            end
         endcase
      end
      // Register reads, data in the following cycle
      if (req.rd) begin
         unique case (req.addr)
            CFG_OFS:  state_next.rdata = state_reg.cfg;
            CTRL_OFS: state_next.rdata = {27'h0, state_reg.id_only, 1'b0, state_reg.ptype};
            STAT_OFS: state_next.rdata = {27'h0, any_bad, type_ok, state_reg.fixed,
                                          state_reg.refused, state_reg.sent};
            VDO_OFS:  state_next.rdata = state_reg.word;
            default:  state_next.rdata = '0;
         endcase
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg         <= '0;
         state_reg.cfg     <= CFG_RESET;
         state_reg.ptype   <= CTRL_RESET[2:0];
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flip-flops
   assign rdata      = state_reg.rdata;
   assign vdo.word   = state_reg.word;
   assign vdo.valid  = state_reg.valid;

endmodule : cable_vdo_encoder

// >>> test/cable_vdo_props.sv
// Purpose: Port checker for the cable identity object encoder
// Assumes: One clock ref_clk, resetn asynchronous active low
// Notes:   Every emitted word is checked for legal codes only
`timescale 1ns/1ps
module cable_vdo_props
   import cable_vdo_pkg::*;
(
   // Clock and reset
   input wire logic                    ref_clk,
   input wire logic                    resetn,
   // Observed ports
   input wire cable_vdo_pkg::reg_req_s req,
   input wire logic [31:0]             rdata,
   input wire logic                    build_req,
   input wire cable_vdo_pkg::vdo_out_s vdo
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Legal field codes on each valid word
   a_ver_zero: assert property (vdo.valid |-> vdo.word[23:21] == VER_1_0)
      else $error("object version not zero");
   a_rsv_zero: assert property (vdo.valid |-> {vdo.word[20], vdo.word[17],
      vdo.word[8:7], vdo.word[4:3]} == 6'h00) else $error("reserved bit set");
   a_plug_legal: assert property (vdo.valid |-> vdo.word[19])
      else $error("reserved plug code");
   a_lat_legal: assert property (vdo.valid |-> vdo.word[16:13] inside {[1:8]})
      else $error("reserved latency code");
   a_term_legal: assert property (vdo.valid |-> !vdo.word[12])
      else $error("reserved termination code");
   a_cur_legal: assert property (vdo.valid |-> vdo.word[6:5] inside {1, 2})
      else $error("reserved current code");
   a_ss_legal: assert property (vdo.valid |-> vdo.word[2:0] <= SS_MAX)
      else $error("reserved signalling code");
   // Read data only in the cycle after a read, word held between builds
   a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 32'h0)
      else $error("read data outside answer cycle");
   a_word_holds: assert property (!vdo.valid |-> $stable(vdo.word))
      else $error("word changed without build");
   c_captive: cover property (vdo.valid && vdo.word[19:18] == PLUG_CAPTIVE);
   c_vconn: cover property (vdo.valid && vdo.word[12:11] == TERM_VCONN);
   c_read_vdo: cover property (req.rd && req.addr == VDO_OFS);
endmodule : cable_vdo_props
bind cable_vdo_encoder cable_vdo_props u_props (.ref_clk(ref_clk), .resetn(resetn),
   .req(req), .rdata(rdata), .build_req(build_req), .vdo(vdo));

// >>> test/pd_tx_model.sv
// Purpose: Host port transmitter asking for and capturing identity objects
// Assumes: Request one cycle after go, capture on vdo.valid
// Notes:   Counts objects so the bench can see refused builds
`timescale 1ns/1ps
module pd_tx_model
   import cable_vdo_pkg::*;
(
   // Clock and reset
   input wire logic                    ref_clk,
   input wire logic                    resetn,
   // Bench command and encoder side
   input wire logic                    go,
   output     logic                    build_req,
   input wire cable_vdo_pkg::vdo_out_s vdo,
   // Captured result
   output     logic [31:0]             last_word,
   output     logic [7:0]              got
);
   // Registered request so it never changes on the sampling edge
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         build_req <= 1'b0;
         last_word <= 32'h0;
         got       <= 8'h00;
      end else begin
         build_req <= go;
         if (vdo.valid) begin
            last_word <= vdo.word;
            got       <= got + 8'h01;
         end
      end
   end
endmodule : pd_tx_model

// >>> test/passive_cable_vdo_encoder_tb.sv
// Purpose: Self-checking bench for the cable identity object encoder
// Assumes: Register port answers one cycle after a read strobe
// Notes:   Random configurations plus all-ones and all-zeros corners
`timescale 1ns/1ps
module passive_cable_vdo_encoder_tb;
   import cable_vdo_pkg::*;
   logic        ref_clk = 1'b0;
   logic        resetn  = 1'b0;
   reg_req_s    req     = '0;
   logic        go      = 1'b0;
   logic        build_req;
   vdo_out_s    vdo;
   logic [31:0] rdata, last_word, d, c, e;
   logic [7:0]  got, g0;
   int          num_errors = 0, checks_done = 0, seed = 51733, i;
   always #50 ref_clk = ~ref_clk;
   cable_vdo_encoder dut (.ref_clk(ref_clk), .resetn(resetn), .req(req), .rdata(rdata),
      .build_req(build_req), .vdo(vdo));
   pd_tx_model partner (.ref_clk(ref_clk), .resetn(resetn), .go(go), .build_req(build_req),
      .vdo(vdo), .last_word(last_word), .got(got));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk) req <= '{a, v, 1'b1, 1'b0};
      @(posedge ref_clk) req <= '0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk) req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge ref_clk) req <= '0;
      #1 v = rdata;
   endtask : rd
   // Set type and identity-only, request once, count answers
   task automatic build(input logic [2:0] pt, input logic io, input logic ok);
      wr(CTRL_OFS, {27'h0, io, 1'b0, pt});
      g0 = got;
      @(posedge ref_clk) go <= 1'b1;
      @(posedge ref_clk) go <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check(got - g0, ok);
   endtask : build
   // Reserved codes are replaced by the designer's safe values
   function automatic logic [31:0] exp_vdo(input logic [31:0] c, input logic io);
      logic [3:0] lat;
      logic [1:0] cur;
      lat = (c[16:13] == 4'h0 || c[16:13] > 4'h8) ? 4'h8 : c[16:13];
      cur = (c[6:5] == 2'h1 || c[6:5] == 2'h2) ? c[6:5] : 2'h1;
      return {c[31:24], 3'h0, 1'b0, c[19] ? c[19:18] : 2'h2, 1'b0, lat,
         (io || c[12]) ? 2'h0 : c[12:11], c[10:9], 2'h0, cur, 2'h0,
         (c[2:0] > 3'h2) ? 3'h0 : c[2:0]};
   endfunction : exp_vdo
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // Hang guard, far beyond the expected few hundred cycles
   initial begin
      #2000000;
      num_errors++;
      give_verdict();
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(CFG_OFS, d);
      check(d, CFG_RESET);
      rd(CTRL_OFS, d);
      check(d, CTRL_RESET);
      rd(8'h10, d);
      check(d, 32'h0);
      for (i = 0; i < 20; i++) begin
         c = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $random(seed);
         wr(CFG_OFS, c);
         build((i % 2) ? PT_ACTIVE : PT_PASSIVE, i[2], 1'b1);
         e = exp_vdo(c, i[2]);
         check(last_word, e);
         rd(VDO_OFS, d);
         check(d, e);
      end
      // Object register is read only
      wr(VDO_OFS, 32'h0);
      rd(VDO_OFS, d);
      check(d, e);
      build(3'h0, 1'b0, 1'b0);
      // Sticky flags: sent, refused and corrected all seen, then cleared by writing ones
      rd(STAT_OFS, d);
      check(d[2:0], 3'h7);
      wr(STAT_OFS, 32'h0000_0007);
      rd(STAT_OFS, d);
      check(d[2:0], 3'h0);
      // Build strobe through the control register
      g0 = got;
      wr(CTRL_OFS, 32'h0000_0104);
      repeat (4) @(posedge ref_clk);
      check(got - g0, 32'h1);
      give_verdict();
   end
endmodule : passive_cable_vdo_encoder_tb
